/* File: design/rrce_pkg.sv */
// Constants for the rotate-right-through-carry execution block.
package rrce_pkg;
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 5;
  localparam int          INSN_W      = 12;
  localparam int          OPC_W       = 6;
  localparam logic [5:0]  OPC_ROTATE  = 6'h0C;
  localparam int          OPC_LSB     = 6;
  localparam int          DEST_BIT    = 5;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic        CARRY_RESET = 1'b0;
  localparam int          NUM_FILES   = 32;
  // Base of the file power-up pattern; the value is arbitrary.
  localparam logic [7:0]  FILE_SEED   = 8'hA5;
endpackage : rrce_pkg

/* File: design/rrce_rot.sv */
// Combinational rotate right through carry.
`timescale 1ns/1ps
module rrce_rot #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] operand,
  input  wire logic             carry_in,
  output logic      [WIDTH-1:0] result,
  output logic                  carry_out
);
  initial begin
    if (WIDTH < 2) begin
      $error("rrce_rot needs WIDTH of at least 2");
    end
  end

  assign result    = {carry_in, operand[WIDTH-1:1]};
  assign carry_out = operand[0];
endmodule : rrce_rot

/* File: design/rrce_exec.sv */
// Executes the rotate-right-through-carry instruction on a file register.
`timescale 1ns/1ps
// How it works
// - Operand rotates right one bit; old carry enters MSB, LSB becomes carry.
// - Destination bit 0 writes result to accumulator; file register unchanged.
// - Destination bit 1 writes result back to the same file register.
// - Opcode is upper six bits 001100, bit 5 destination, low five address.
// - Only carry changes among status bits; operand is read before write.
module rrce_exec
  import rrce_pkg::*;
#(
  parameter int NFILES = rrce_pkg::NUM_FILES
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        insn_valid,
  input  wire logic [rrce_pkg::INSN_W-1:0] insn,
  output logic      [rrce_pkg::DATA_W-1:0] acc,
  output logic                             carry,
  output logic                             op_done,
  output logic                             file_we,
  output logic      [rrce_pkg::ADDR_W-1:0] file_waddr,
  output logic      [rrce_pkg::DATA_W-1:0] file_wdata,
  output logic      [rrce_pkg::DATA_W-1:0] file_rdata
);
  import rrce_pkg::*;

  // Opcode match, shared by the decode path and the refusal check.
  function automatic logic is_rotate_word(input logic [INSN_W-1:0] word);
    return word[INSN_W-1:OPC_LSB] == OPC_ROTATE;
  endfunction : is_rotate_word

  // Each file gets its own power-up value, so rotates move real data.
  function automatic logic [DATA_W-1:0] file_reset_value(input int idx);
    return FILE_SEED ^ DATA_W'(idx);
  endfunction : file_reset_value

  initial begin
    if (NFILES != (1 << ADDR_W)) begin
      $error("rrce_exec NFILES must match the address width");
    end
  end

  // The file registers live here because the core offers no file port.
  // Resetting them costs a little logic, but without it every operand,
  // and through the carry every later result, would stay unknown.
  logic [DATA_W-1:0] files [NFILES];

  wire               is_rot;
  wire               dest_file;
  wire [ADDR_W-1:0]  faddr;
  wire [DATA_W-1:0]  operand;
  wire [DATA_W-1:0]  rot_result;
  wire               rot_carry;
  wire               exec;

  assign is_rot    = is_rotate_word(insn);
  assign dest_file = insn[DEST_BIT];
  assign faddr     = insn[ADDR_W-1:0];
  assign exec      = insn_valid && is_rot;
  // Operand is sampled from the old content before any write lands.
  assign operand   = files[faddr];

  rrce_rot #(
    .WIDTH     (DATA_W)
  ) u_rot (
    .operand   (operand),
    .carry_in  (carry),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc   <= ACC_RESET;
      carry <= CARRY_RESET;
    end else if (exec) begin
      carry <= rot_carry;
      if (!dest_file) begin
        acc <= rot_result;
      end
    end
  end

  // Only the write-back path touches the files after reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NFILES; i++) begin
        files[i] <= file_reset_value(i);
      end
    end else if (exec && dest_file) begin
      files[faddr] <= rot_result;
    end
  end

  // The observation outputs are registered copies of this cycle's work,
  // so every top-level output comes straight from a flip-flop. They lag
  // the instruction by one cycle, exactly like the accumulator and carry.

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_done    <= 1'b0;
      file_we    <= 1'b0;
      file_waddr <= '0;
      file_wdata <= '0;
      file_rdata <= '0;
    end else begin
      op_done    <= exec;
      file_we    <= exec && dest_file;
      file_waddr <= faddr;
      file_wdata <= rot_result;
      file_rdata <= operand;
    end
  end

  // Checks below that involve the operand use the value taken before the
  // write-back, which is the value the instruction is defined on.
  AST_ROTATE_ACC: assert property (
    @(posedge clk) disable iff (!nrst)
    exec && !dest_file |=> acc == {$past(carry), $past(operand[DATA_W-1:1])})
    else $error("Accumulator does not hold the rotated operand.");

  AST_CARRY_LSB: assert property (
    @(posedge clk) disable iff (!nrst)
    exec |=> carry == $past(operand[0]))
    else $error("Carry did not take the operand low bit.");

  AST_ACC_HOLD: assert property (
    @(posedge clk) disable iff (!nrst)
    exec && dest_file |=> $stable(acc))
    else $error("Accumulator changed on a file write-back.");

  AST_FILE_HOLD: assert property (
    @(posedge clk) disable iff (!nrst)
    exec && !dest_file |=> files[$past(faddr)] == $past(operand))
    else $error("File register changed when result went to accumulator.");

  AST_FILE_WB: assert property (
    @(posedge clk) disable iff (!nrst)
    exec && dest_file |=> file_we && files[file_waddr] == file_wdata)
    else $error("Rotated value not written back to the file register.");

  AST_DECODE: assert property (
    @(posedge clk) disable iff (!nrst)
    insn_valid && !is_rotate_word(insn)
      |=> !op_done && $stable(carry) && $stable(acc))
    else $error("Foreign opcode was executed.");

  AST_ONE_CYCLE: assert property (
    @(posedge clk) disable iff (!nrst)
    exec ##1 exec && faddr == $past(faddr) && !$past(dest_file)
      |-> rot_carry == $past(operand[0]) && carry == $past(rot_carry))
    else $error("Result was not visible to the next instruction.");

  AST_IDLE_HOLD: assert property (
    @(posedge clk) disable iff (!nrst)
    !exec |=> $stable(carry) && !op_done)
    else $error("Status changed without an executed instruction.");

  AST_DONE_PULSE: assert property (
    @(posedge clk) disable iff (!nrst)
    exec |=> op_done)
    else $error("Executed rotate gave no done pulse.");

  AST_ACC_NO_WE: assert property (
    @(posedge clk) disable iff (!nrst)
    exec && !dest_file |=> !file_we)
    else $error("File write strobe raised for an accumulator result.");

  AST_RDATA_OLD: assert property (
    @(posedge clk) disable iff (!nrst)
    exec |=> file_rdata == $past(operand))
    else $error("Observed operand is not the value before write-back.");

  AST_WDATA_ROT: assert property (
    @(posedge clk) disable iff (!nrst)
    exec |=> file_wdata == {$past(carry), $past(operand[DATA_W-1:1])})
    else $error("Observed result is not the rotated operand.");

  AST_MSB_CARRY: assert property (
    @(posedge clk) disable iff (!nrst)
    exec && dest_file |=> file_wdata[DATA_W-1] == $past(carry))
    else $error("Old carry did not enter the top bit.");

  AST_WADDR: assert property (
    @(posedge clk) disable iff (!nrst)
    exec |=> file_waddr == $past(faddr))
    else $error("Observed address is not the decoded file address.");

  AST_ACC_IDLE: assert property (
    @(posedge clk) disable iff (!nrst)
    !exec |=> $stable(acc))
    else $error("Accumulator changed without an executed instruction.");

  AST_FILE_IDLE: assert property (
    @(posedge clk) disable iff (!nrst)
    !exec |=> files[$past(faddr)] == $past(operand))
    else $error("File register changed without an executed instruction.");

  AST_NO_WE_IDLE: assert property (
    @(posedge clk) disable iff (!nrst)
    !exec |=> !file_we)
    else $error("File write strobe raised without an executed rotate.");

  // Cover points for the main scenarios of the bench.
  COV_TO_ACC: cover property (@(posedge clk) disable iff (!nrst)
    exec && !dest_file);
  COV_TO_FILE: cover property (@(posedge clk) disable iff (!nrst)
    exec && dest_file);
  COV_BACK_TO_BACK: cover property (@(posedge clk) disable iff (!nrst)
    exec ##1 exec);
  COV_CARRY_SET: cover property (@(posedge clk) disable iff (!nrst)
    exec && carry && rot_carry);
  COV_REFUSED: cover property (@(posedge clk) disable iff (!nrst)
    insn_valid && !is_rotate_word(insn));
endmodule : rrce_exec

/* File: verif/testbench.sv */
// Self-checking testbench for the rotate-right-through-carry block.
`timescale 1ns/1ps
module testbench;
  import rrce_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        insn_valid = 1'b0;
  logic [11:0] insn = 12'h000;
  logic [7:0]  acc, file_wdata, file_rdata, m_acc, r;
  logic [7:0]  mf [32];
  logic [4:0]  file_waddr;
  logic        carry, op_done, file_we, m_c;
  int          errors = 0;
  int          checks = 0;
  // Columns: valid, word, expected done, expected write strobe.
  localparam logic [14:0] ROWS [10] = '{
    {1'b1, 12'h325, 2'b11}, {1'b1, 12'h305, 2'b10},
    {1'b1, 12'h305, 2'b10}, {1'b0, 12'h325, 2'b00},
    {1'b1, 12'h345, 2'b00}, {1'b1, 12'h33F, 2'b11},
    {1'b1, 12'h31F, 2'b10}, {1'b1, 12'h300, 2'b10},
    {1'b1, 12'h320, 2'b11}, {1'b1, 12'h305, 2'b10}};
  rrce_exec rrce_exec_i (.clk(clk), .nrst(nrst), .insn_valid(insn_valid),
    .insn(insn), .acc(acc), .carry(carry), .op_done(op_done),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .file_rdata(file_rdata));
  initial forever #50 clk = ~clk;
  task chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Reset gives each file its own pattern, so rotates move known data.
  task model_reset;
    foreach (mf[i]) mf[i] = FILE_SEED ^ 8'(i);
    m_acc = ACC_RESET;
    m_c   = CARRY_RESET;
  endtask : model_reset
  task run_rows;
    logic [14:0] w;
    for (int k = 0; k <= 10; k++) begin
      @(posedge clk);
      insn_valid <= (k < 10) ? ROWS[k][14] : 1'b0;
      insn       <= (k < 10) ? ROWS[k][13:2] : 12'h000;
      @(negedge clk);
      if (k > 0) begin
        w = ROWS[k-1];
        chk("op_done", {7'h00, w[1]}, {7'h00, op_done});
        chk("file_we", {7'h00, w[0]}, {7'h00, file_we});
        if (w[1]) begin
          r = mf[w[6:2]];
          chk("file_rdata", r, file_rdata);
          chk("file_wdata", {m_c, r[7:1]}, file_wdata);
          chk("file_waddr", {3'h0, w[6:2]}, {3'h0, file_waddr});
          if (w[0]) mf[w[6:2]] = {m_c, r[7:1]};
          else m_acc = {m_c, r[7:1]};
          m_c = r[0];
        end
        chk("acc", m_acc, acc);
        chk("carry", {7'h00, m_c}, {7'h00, carry});
      end
    end
    $display("table pass done");
  endtask : run_rows
  // A reset in mid-run puts carry, accumulator and files back to start.
  task reset_check;
    @(posedge clk);
    nrst <= 1'b0;
    @(negedge clk);
    chk("acc", ACC_RESET, acc);
    chk("carry", {7'h00, CARRY_RESET}, {7'h00, carry});
    chk("op_done", 8'h00, {7'h00, op_done});
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    model_reset;
    $display("reset test done");
  endtask : reset_check
  initial begin
    model_reset;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    run_rows;
    reset_check;
    run_rows;
    stop_test;
  end
  initial begin
    #200000;
    errors++;
    stop_test;
  end
endmodule : testbench
